// ---- rtl/rss_core.sv ----
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wdog_tick,
    output logic             osc_run,
    output logic      [7:0]  watchdog_counter,
    output logic      [7:0]  wdog_postscale
);

    rss_pkg::rss_state_t state_q, state_d;
    rss_pkg::rss_kind_t  kind_q, kind_d;
    logic [15:0] instr_q, instr_d;
    logic [7:0]  acc_q, acc_d;
    logic [3:0]  bank_select_reg_q, bank_select_reg_d;
    logic        neg_q, neg_d, zero_q, zero_d;
    logic        powerdown_flag_q, powerdown_flag_d;
    logic        timeout_flag_q, timeout_flag_d;
    logic [7:0]  wdog_q, wdog_d, post_q, post_d;
    logic [7:0]  result_q, result_d;
    logic [31:0] prdata_q, prdata_d;
    logic        mem_we;
    logic [11:0] mem_raddr, mem_waddr, eff_addr;
    logic [7:0]  mem_rdata, mem_wdata;
    logic        setup, wr_acc, rd_acc, mem_rd_phase;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] rss_ea(input logic [15:0] ins, input logic [3:0] bank_select_reg);
        if (ins[8]) begin
            rss_ea = {bank_select_reg, ins[7:0]};
        end else if (ins[7:0] >= `RSS_ACCESS_SPLIT) begin
            rss_ea = {`RSS_ACCESS_HIGH_BK, ins[7:0]};
        end else begin
            rss_ea = {`RSS_BANK_RST, ins[7:0]};
        end
    endfunction

    function automatic rss_pkg::rss_kind_t rss_decode(input logic [15:0] ins);
        if (ins[15:10] == `RSS_OP_ROR_PREFIX) begin
            rss_decode = rss_pkg::RSS_K_ROR;
        end else if (ins[15:9] == `RSS_OP_SET_PREFIX) begin
            rss_decode = rss_pkg::RSS_K_SET;
        end else if (ins == `RSS_OP_SLEEP_WORD) begin
            rss_decode = rss_pkg::RSS_K_SLEEP;
        end else begin
            rss_decode = rss_pkg::RSS_K_NONE;
        end
    endfunction

    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    assign setup   = psel && !penable;
    assign pready  = psel && penable;
    assign pslverr = 1'b0;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = setup && !pwrite;
    assign eff_addr = rss_ea(instr_q, bank_select_reg_q);

    // Software file reads use the memory port during setup; the core holds
    // it in Q1 and Q2 so the operand still stands when Q3 processes it.
    assign mem_rd_phase = (state_q == rss_pkg::RSS_Q1) || (state_q == rss_pkg::RSS_Q2);
    assign mem_raddr = mem_rd_phase ? eff_addr : pwdata[11:0];

    rss_file_mem u_mem (
        .pclk  (pclk),
        .raddr (mem_raddr),
        .rdata (mem_rdata),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        instr_d = instr_q;
        acc_d = acc_q;
        bank_select_reg_d = bank_select_reg_q;
        neg_d = neg_q;
        zero_d = zero_q;
        powerdown_flag_d = powerdown_flag_q;
        timeout_flag_d = timeout_flag_q;
        wdog_d = wdog_q;
        post_d = post_q;
        result_d = result_q;
        mem_we = 1'b0;
        mem_waddr = eff_addr;
        mem_wdata = result_q;

        // Watchdog keeps running only while the oscillator does
        // A tick in the last phase of power-down would undo the clear
        if (wdog_tick && state_q != rss_pkg::RSS_SLEEP &&
            !(state_q == rss_pkg::RSS_Q4 && kind_q == rss_pkg::RSS_K_SLEEP)) begin
            post_d = post_q + 8'h01;
            if (post_q == 8'hff) begin
                wdog_d = wdog_q + 8'h01;
            end
        end

        case (state_q)
            rss_pkg::RSS_IDLE: begin
                if (wr_acc && paddr == `RSS_ADDR_INSTR) begin
                    instr_d = pwdata[15:0];
                    state_d = rss_pkg::RSS_Q1;
                end
            end
            rss_pkg::RSS_Q1: begin
                kind_d = rss_decode(instr_q);
                if (rss_decode(instr_q) == rss_pkg::RSS_K_SLEEP) begin
                    powerdown_flag_d = 1'b0;
                end
                state_d = rss_pkg::RSS_Q2;
            end
            rss_pkg::RSS_Q2: begin
                state_d = rss_pkg::RSS_Q3;
            end
            rss_pkg::RSS_Q3: begin
                case (kind_q)
                    rss_pkg::RSS_K_ROR: begin
                        result_d = {mem_rdata[0], mem_rdata[7:1]};
                        neg_d = mem_rdata[0];
                        zero_d = (mem_rdata == 8'h00);
                    end
                    rss_pkg::RSS_K_SET: result_d = `RSS_ALL_ONES;
                    rss_pkg::RSS_K_SLEEP: begin
                        timeout_flag_d = 1'b1;
                        wdog_d = `RSS_WDOG_CLR;
                        post_d = `RSS_WDOG_CLR;
                    end
                    default: result_d = result_q;
                endcase
                state_d = rss_pkg::RSS_Q4;
            end
            rss_pkg::RSS_Q4: begin
                state_d = rss_pkg::RSS_IDLE;
                case (kind_q)
                    rss_pkg::RSS_K_ROR: begin
                        if (instr_q[9]) begin
                            mem_we = 1'b1;
                        end else begin
                            acc_d = result_q;
                        end
                    end
                    rss_pkg::RSS_K_SET: mem_we = 1'b1;
                    rss_pkg::RSS_K_SLEEP: state_d = rss_pkg::RSS_SLEEP;
                    default: state_d = rss_pkg::RSS_IDLE;
                endcase
            end
            rss_pkg::RSS_SLEEP: begin
                if (wr_acc && paddr == `RSS_ADDR_WAKE && pwdata[0]) begin
                    state_d = rss_pkg::RSS_IDLE;
                end
            end
            default: state_d = rss_pkg::RSS_IDLE;
        endcase

        // Software register writes; core write in Q4 has priority on the port
        if (wr_acc) begin
            case (paddr)
                `RSS_ADDR_BANK: bank_select_reg_d = pwdata[3:0];
                `RSS_ADDR_ACC:  acc_d = pwdata[7:0];
                `RSS_ADDR_FILE: begin
                    if (!mem_we) begin
                        mem_we = 1'b1;
                        mem_waddr = pwdata[19:8];
                        mem_wdata = pwdata[7:0];
                    end
                end
                default: acc_d = acc_d;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Captured at the setup edge and held until the next read setup
    always_comb begin
        prdata_d = prdata_q;
        if (rd_acc) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                `RSS_ADDR_INSTR:  prdata_d = {16'h0000, instr_q};
                `RSS_ADDR_STATUS: begin
                    prdata_d[`RSS_ST_NEG]   = neg_q;
                    prdata_d[`RSS_ST_ZERO]  = zero_q;
                    prdata_d[`RSS_ST_PD]    = powerdown_flag_q;
                    prdata_d[`RSS_ST_TO]    = timeout_flag_q;
                    prdata_d[`RSS_ST_BUSY]  = (state_q != rss_pkg::RSS_IDLE) && (state_q != rss_pkg::RSS_SLEEP);
                    prdata_d[`RSS_ST_SLEEP] = (state_q == rss_pkg::RSS_SLEEP);
                end
                `RSS_ADDR_BANK:   prdata_d = {28'h0000000, bank_select_reg_q};
                `RSS_ADDR_ACC:    prdata_d = {24'h000000, acc_q};
                `RSS_ADDR_WDOG:   prdata_d = {16'h0000, post_q, wdog_q};
                default:          prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rss_pkg::RSS_IDLE;
            kind_q <= rss_pkg::RSS_K_NONE;
            instr_q <= 16'h0000;
            acc_q <= `RSS_ACC_RST;
            bank_select_reg_q <= `RSS_BANK_RST;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
            wdog_q <= `RSS_WDOG_CLR;
            post_q <= `RSS_WDOG_CLR;
            result_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            bank_select_reg_q <= bank_select_reg_d;
            neg_q <= neg_d;
            zero_q <= zero_d;
            powerdown_flag_q <= powerdown_flag_d;
            timeout_flag_q <= timeout_flag_d;
            wdog_q <= wdog_d;
            post_q <= post_d;
            result_q <= result_d;
            prdata_q <= prdata_d;
        end
    end

    // File data comes straight from the memory's output register, which the
    // setup edge loaded; it is only valid in the access phase
    assign prdata = (paddr == `RSS_ADDR_FILE) ? {24'h000000, mem_rdata} : prdata_q;
    assign osc_run = (state_q != rss_pkg::RSS_SLEEP);
    assign watchdog_counter = wdog_q;
    assign wdog_postscale = post_q;

endmodule

// ---- shared/rss_cfg.svh ----
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// Opcode patterns (top 6 or 7 bits of the 16-bit word; sleep is the whole word)
`define RSS_OP_ROR_PREFIX   6'h10
`define RSS_OP_SET_PREFIX   7'h34
`define RSS_OP_SLEEP_WORD   16'h0003

// Register offsets (byte addresses)
`define RSS_ADDR_INSTR      12'h000
`define RSS_ADDR_STATUS     12'h004
`define RSS_ADDR_BANK       12'h008
`define RSS_ADDR_ACC        12'h00c
`define RSS_ADDR_WAKE       12'h010
`define RSS_ADDR_WDOG       12'h014
`define RSS_ADDR_FILE       12'h018

// Status register bit positions
`define RSS_ST_NEG          0
`define RSS_ST_ZERO         1
`define RSS_ST_PD           2
`define RSS_ST_TO           3
`define RSS_ST_BUSY         4
`define RSS_ST_SLEEP        5

// Reset values and the set-all-ones result
`define RSS_ACC_RST         8'h00
`define RSS_BANK_RST        4'h0
`define RSS_ALL_ONES        8'hff
`define RSS_WDOG_CLR        8'h00

// Access bank: low half maps to bank 0, high half to bank 15
`define RSS_ACCESS_SPLIT    8'h80
`define RSS_ACCESS_HIGH_BK  4'hf

`endif

// ---- shared/rss_pkg.sv ----
package rss_pkg;

    typedef enum logic [2:0] {
        RSS_IDLE  = 3'b000,
        RSS_Q1    = 3'b001,
        RSS_Q2    = 3'b010,
        RSS_Q3    = 3'b011,
        RSS_Q4    = 3'b100,
        RSS_SLEEP = 3'b101
    } rss_state_t;

    typedef enum logic [1:0] {
        RSS_K_NONE  = 2'b00,
        RSS_K_ROR   = 2'b01,
        RSS_K_SET   = 2'b10,
        RSS_K_SLEEP = 2'b11
    } rss_kind_t;

endpackage

// ---- rtl/rss_file_mem.sv ----
`timescale 1ns/1ps

module rss_file_mem (
    input  wire logic        pclk,
    input  wire logic [11:0] raddr,
    output logic      [7:0]  rdata,
    input  wire logic        we,
    input  wire logic [11:0] waddr,
    input  wire logic [7:0]  wdata
);

    // Data memory has no reset; software or the core initialises it
    logic [7:0] mem [0:4095];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// ---- testbench/rss_core_chk.sv ----
`timescale 1ns/1ps

module rss_core_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        osc_run,
    input wire logic [7:0]  watchdog_counter,
    input wire logic [7:0]  wdog_postscale
);
    // --------
    // Idle tracker
    // --------
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       take;
    logic       slp;
    logic       sr;
    // Writes while busy are refused, so only idle ones count
    assign take = psel && penable && pwrite && paddr == 12'h000 && osc_run && cnt_q == 3'h0;
    assign slp  = take && pwdata[15:0] == 16'h0003;
    assign sr   = psel && penable && !pwrite && paddr == 12'h004 && !osc_run;
    always_comb begin
        cnt_d = (cnt_q == 3'h0) ? 3'h0 : cnt_q - 3'h1;
        if (take) begin
            cnt_d = 3'h5;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_zw; psel && penable |-> pready; endproperty
    a_zw: assert property (p_zw) else $error("access not zero wait");
    property p_ph; slp |-> ##1 osc_run [*4] ##1 !osc_run; endproperty
    a_ph: assert property (p_ph) else $error("power-down phases wrong");
    property p_osc; slp |-> ##5 !osc_run [*3]; endproperty
    a_osc: assert property (p_osc) else $error("oscillator not halted");
    property p_frz; !osc_run && !$past(osc_run) |-> $stable(wdog_postscale); endproperty
    a_frz: assert property (p_frz) else $error("postscaler moves asleep");
    property p_wdc; slp |-> ##5 watchdog_counter == 8'h00 && wdog_postscale == 8'h00; endproperty
    a_wdc: assert property (p_wdc) else $error("watchdog not cleared");
    property p_wdh; !osc_run |-> watchdog_counter == 8'h00; endproperty
    a_wdh: assert property (p_wdh) else $error("watchdog nonzero asleep");
    property p_pd; sr |-> !prdata[2]; endproperty
    a_pd: assert property (p_pd) else $error("power-down flag set asleep");
    property p_to; sr |-> prdata[3]; endproperty
    a_to: assert property (p_to) else $error("time-out flag clear asleep");
endmodule

bind rss_core rss_core_chk rss_core_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .osc_run(osc_run),
    .watchdog_counter(watchdog_counter), .wdog_postscale(wdog_postscale)
);

// ---- testbench/rotate_set_sleep_exec_test.sv ----
`timescale 1ns/1ps

module rotate_set_sleep_exec_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        wdog_tick;
    logic        osc_run;
    logic [31:0] r;
    int          fail_count;
    int          checks_done;

    rss_core rss_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .wdog_tick(wdog_tick), .osc_run(osc_run), .watchdog_counter(), .wdog_postscale()
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // --------
    // Tasks
    // --------
    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks_done++;
        if (got !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // One idle cycle after each transfer keeps a signal from being driven twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) fail_count++;
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    task automatic fr(input logic [11:0] f, input logic [7:0] e);
        apb(1'b0, 12'h018, {20'h0, f});
        chk(r, {24'h0, e});
    endtask

    task automatic fw(input logic [11:0] f, input logic [7:0] v);
        apb(1'b1, 12'h018, {12'h0, f, v});
    endtask

    // Polls status until neither busy nor still heading to sleep
    task automatic ex(input logic [15:0] w);
        int n;
        n = 0;
        apb(1'b1, 12'h000, {16'h0, w});
        do begin
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end while (r[4] !== 1'b0 && r[5] !== 1'b1 && n < 9);
        if (n >= 9) fail_count++;
    endtask

    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end

    // --------
    // Tests
    // --------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        wdog_tick = 1'b0;
        fail_count = 0;
        checks_done = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wdog_tick <= 1'b1;
        @(posedge pclk);
        rd(12'h004, 32'h0c);
        fw(12'h010, 8'hd7);
        ex(16'h4210);
        fr(12'h010, 8'heb);
        rd(12'h004, 32'h0d);
        ex(16'h4010);
        rd(12'h00c, 32'hf5);
        fr(12'h010, 8'heb);
        apb(1'b1, 12'h008, 32'h3);
        fw(12'hf85, 8'h01);
        fw(12'h385, 8'h55);
        ex(16'h4285);
        fr(12'hf85, 8'h80);
        fr(12'h385, 8'h55);
        ex(16'h4385);
        fr(12'h385, 8'haa);
        fw(12'h020, 8'h00);
        ex(16'h4220);
        rd(12'h004, 32'h0e);
        // set all ones, second word lands while busy
        apb(1'b1, 12'h000, 32'h6920);
        ex(16'h4120);
        fr(12'h320, 8'hff);
        rd(12'h00c, 32'hf5);
        rd(12'h004, 32'h0e);
        ex(16'h6890);
        fr(12'hf90, 8'hff);
        ex(16'h0003);
        chk({31'h0, osc_run}, 32'h0);
        rd(12'h004, 32'h2a);
        rd(12'h014, 32'h0);
        apb(1'b1, 12'h000, 32'h4020);
        repeat (6) @(posedge pclk);
        rd(12'h00c, 32'hf5);
        apb(1'b1, 12'h010, 32'h1);
        for (int i = 0; i < 8 && osc_run !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, osc_run}, 32'h1);
        rd(12'h004, 32'h0a);
        end_of_test();
    end
endmodule
